// file: sdram_ecc_pkg.sv
// shared constants and types for the ecc sdram datapath
package sdram_ecc_pkg;

	// word organisation inside the array
	localparam int DQ_W    = 32;
	localparam int DATA_W  = 64;
	localparam int CHK_W   = 8;
	localparam int CODE_W  = 72;
	localparam int HAM_W   = 7;
	localparam int BANKS   = 4;
	localparam int BANK_W  = 2;
	localparam int ADDR_W  = 12;
	localparam int DQM_W   = 4;

	// command code {cs_n, ras_n, cas_n, we_n}
	typedef enum logic [3:0] {
		CMD_MRS = 4'h0,
		CMD_REF = 4'h1,
		CMD_PRE = 4'h2,
		CMD_ACT = 4'h3,
		CMD_WR  = 4'h4,
		CMD_RD  = 4'h5,
		CMD_BST = 4'h6,
		CMD_NOP = 4'h7
	} cmd_e;

	// mode word fields on the address pins
	localparam int MODE_BL_LSB     = 0;
	localparam int MODE_WRAP_BIT   = 3;
	localparam int MODE_CL_LSB     = 4;
	localparam int MODE_WSINGLE_BIT = 9;
	localparam int PRE_ALL_BIT     = 10;

	// burst length and latency codes
	localparam logic [2:0] BL_1    = 3'h0;
	localparam logic [2:0] BL_2    = 3'h1;
	localparam logic [2:0] BL_4    = 3'h2;
	localparam logic [2:0] BL_8    = 3'h3;
	localparam logic [2:0] BL_PAGE = 3'h7;
	localparam logic [2:0] CL_2    = 3'h2;
	localparam logic [2:0] CL_3    = 3'h3;

	// mode after reset
	localparam logic [2:0] RST_BL      = BL_1;
	localparam logic       RST_CL3     = 1'b1;
	localparam logic       RST_ILV     = 1'b0;
	localparam logic       RST_WSINGLE = 1'b0;

endpackage

// file: sdram_word_store.sv
// array of 72-bit coded words, one write port and one registered read port
`timescale 1ns/1ps
`default_nettype none
module sdram_word_store #(
	parameter int AW = 21,
	parameter int DW = 72
) (
	input  wire logic          clk,
	input  wire logic          wr_en,
	input  wire logic [AW-1:0] wr_addr,
	input  wire logic [DW-1:0] wr_data,
	input  wire logic [AW-1:0] rd_addr,
	output logic      [DW-1:0] rd_data
);

	logic [DW-1:0] mem [0:(1<<AW)-1];
	logic [DW-1:0] rd_data_reg;
	logic [DW-1:0] rd_data_next;

	// write-first: a read of the word being written sees the new value
	always_comb begin
		if (wr_en && (wr_addr == rd_addr)) begin
			rd_data_next = wr_data;
		end else begin
			rd_data_next = mem[rd_addr];
		end
	end

	always_ff @(posedge clk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
		rd_data_reg <= rd_data_next;
	end

	assign rd_data = rd_data_reg;

endmodule // sdram_word_store
`default_nettype wire

// file: sdram_inline_ecc_datapath.sv
// ecc sdram core: command decode, bursts, check-bit generation, correction
`timescale 1ns/1ps
`default_nettype none
module sdram_inline_ecc_datapath #(
	parameter int ROW_W = 12,
	parameter int COL_W = 8
) (
	input  wire logic                           mclk,
	input  wire logic                           reset_n,
	input  wire logic                           cke,
	input  wire logic                           cs_n,
	input  wire logic                           ras_n,
	input  wire logic                           cas_n,
	input  wire logic                           we_n,
	input  wire logic [sdram_ecc_pkg::ADDR_W-1:0] addr,
	input  wire logic                           bank_select_low,
	input  wire logic                           bank_select_high,
	input  wire logic [sdram_ecc_pkg::DQM_W-1:0]  dqm,
	input  wire logic [sdram_ecc_pkg::DQ_W-1:0]   dq_in,
	output logic      [sdram_ecc_pkg::DQ_W-1:0]   dq_out,
	output logic                                dq_oe
);

	localparam int WA_W = sdram_ecc_pkg::BANK_W + ROW_W + COL_W - 1;

	// hamming layout: position 0 overall parity, powers of two check bits
	function automatic logic [71:0] spread(input logic [63:0] d,
		input logic [7:0] c);
		logic [71:0] cw;
		int j;
		int k;
		cw = '0;
		j = 0;
		k = 0;
		for (int p = 1; p < 72; p++) begin
			if ((p & (p - 1)) == 0) begin
				cw[p] = c[k];
				k = k + 1;
			end else begin
				cw[p] = d[j];
				j = j + 1;
			end
		end
		cw[0] = c[7];
		return cw;
	endfunction

	// parity of each syndrome group over a spread codeword
	function automatic logic [6:0] groups(input logic [71:0] cw);
		logic [6:0] s;
		s = '0;
		for (int k = 0; k < 7; k++) begin
			for (int p = 1; p < 72; p++) begin
				if (((p >> k) & 1) == 1) begin
					s[k] = s[k] ^ cw[p];
				end
			end
		end
		return s;
	endfunction

	// check bits for one data word
	function automatic logic [7:0] ecc_encode(input logic [63:0] d);
		logic [6:0] h;
		h = groups(spread(d, 8'h00));
		return {^{d, h}, h};
	endfunction

	// single-error correction of one stored word, no error reporting
	function automatic logic [63:0] ecc_correct(input logic [71:0] w);
		logic [71:0] cw;
		logic [6:0]  syn;
		logic [63:0] d;
		int j;
		cw  = spread(w[63:0], w[71:64]);
		syn = groups(cw);
		if ((^w) && (syn != 7'h00) && (syn < 7'h48)) begin
			cw[syn] = ~cw[syn];
		end
		j = 0;
		d = '0;
		for (int p = 1; p < 72; p++) begin
			if ((p & (p - 1)) != 0) begin
				d[j] = cw[p];
				j = j + 1;
			end
		end
		return d;
	endfunction

	// burst length code to column wrap mask
	function automatic logic [COL_W-1:0] mask_of(input logic [2:0] code);
		case (code)
			sdram_ecc_pkg::BL_2:    mask_of = COL_W'(1);
			sdram_ecc_pkg::BL_4:    mask_of = COL_W'(3);
			sdram_ecc_pkg::BL_8:    mask_of = COL_W'(7);
			sdram_ecc_pkg::BL_PAGE: mask_of = '1;
			default:                mask_of = '0;
		endcase
	endfunction

	// column of beat idx, wrapping inside the burst block
	function automatic logic [COL_W-1:0] col_at(input logic [COL_W-1:0] s,
		input logic [COL_W-1:0] i, input logic [COL_W-1:0] m,
		input logic ilv);
		logic [COL_W-1:0] low;
		low = ilv ? (s ^ i) : (s + i);
		return (s & ~m) | (low & m);
	endfunction

	sdram_ecc_pkg::cmd_e cmd;
	logic [1:0]        bank;
	logic              cmd_rw;
	logic              stop;

	// mode and open rows
	logic              cl3_reg, cl3_next;
	logic [2:0]        bl_reg, bl_next;
	logic              ilv_reg, ilv_next;
	logic              wsingle_reg, wsingle_next;
	logic [ROW_W-1:0]  row_reg [sdram_ecc_pkg::BANKS];
	logic [ROW_W-1:0]  row_next [sdram_ecc_pkg::BANKS];

	// burst sequencer
	logic              bst_on_reg, bst_on_next;
	logic              bst_wr_reg, bst_wr_next;
	logic              bst_page_reg, bst_page_next;
	logic [1:0]        bst_bank_reg, bst_bank_next;
	logic [COL_W-1:0]  bst_start_reg, bst_start_next;
	logic [COL_W-1:0]  bst_idx_reg, bst_idx_next;
	logic [COL_W-1:0]  bst_mask_reg, bst_mask_next;
	logic              beat_on, beat_wr, beat_half;
	logic [1:0]        beat_bank;
	logic [COL_W-1:0]  beat_col;
	logic [WA_W-1:0]   beat_word;

	// read pipe
	logic              p1_rd_reg, p1_rd_next;
	logic              p1_half_reg, p1_half_next;
	logic              hold_v_reg, hold_v_next;
	logic [31:0]       hold_reg, hold_next;
	logic [31:0]       dq_out_reg, dq_out_next;
	logic              dq_oe_reg, dq_oe_next;
	logic [71:0]       rd_word;
	logic [63:0]       corr;
	logic [31:0]       slice;

	// write merge buffer
	logic              wb_v_reg, wb_v_next;
	logic              wb_fresh_reg, wb_fresh_next;
	logic [WA_W-1:0]   wb_addr_reg, wb_addr_next;
	logic [63:0]       wb_data_reg, wb_data_next;
	logic [7:0]        wb_be_reg, wb_be_next;
	logic [63:0]       old_reg, old_next;
	logic [63:0]       old_use, merged;
	logic              wr_beat, new_word, flush;

	// all pins are synchronous to mclk, so no synchroniser is needed
	assign cmd    = sdram_ecc_pkg::cmd_e'({cs_n, ras_n, cas_n, we_n});
	assign bank   = {bank_select_high, bank_select_low};
	assign cmd_rw = cke && ((cmd == sdram_ecc_pkg::CMD_RD) ||
		(cmd == sdram_ecc_pkg::CMD_WR));

	// mode register load and row activation; no mode bit reaches ecc
	always_comb begin
		cl3_next     = cl3_reg;
		bl_next      = bl_reg;
		ilv_next     = ilv_reg;
		wsingle_next = wsingle_reg;
		row_next     = row_reg;
		if (cke) begin
			case (cmd)
				sdram_ecc_pkg::CMD_ACT: begin
					row_next[bank] = addr[ROW_W-1:0];
				end
				sdram_ecc_pkg::CMD_MRS: begin
					// illegal pairs leave the mode untouched
					if (((addr[sdram_ecc_pkg::MODE_CL_LSB+:3] ==
						sdram_ecc_pkg::CL_2) ||
						(addr[sdram_ecc_pkg::MODE_CL_LSB+:3] ==
						sdram_ecc_pkg::CL_3)) &&
						!((addr[sdram_ecc_pkg::MODE_BL_LSB+:3] ==
						sdram_ecc_pkg::BL_PAGE) &&
						addr[sdram_ecc_pkg::MODE_WRAP_BIT])) begin
						cl3_next = (addr[sdram_ecc_pkg::MODE_CL_LSB+:3] ==
							sdram_ecc_pkg::CL_3);
						bl_next  = addr[sdram_ecc_pkg::MODE_BL_LSB+:3];
						ilv_next = addr[sdram_ecc_pkg::MODE_WRAP_BIT];
						wsingle_next = addr[sdram_ecc_pkg::MODE_WSINGLE_BIT];
					end
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			cl3_reg     <= sdram_ecc_pkg::RST_CL3;
			bl_reg      <= sdram_ecc_pkg::RST_BL;
			ilv_reg     <= sdram_ecc_pkg::RST_ILV;
			wsingle_reg <= sdram_ecc_pkg::RST_WSINGLE;
			row_reg     <= '{default: '0};
		end else begin
			cl3_reg     <= cl3_next;
			bl_reg      <= bl_next;
			ilv_reg     <= ilv_next;
			wsingle_reg <= wsingle_next;
			row_reg     <= row_next;
		end
	end

	// beat of this cycle and next burst state; cke low suspends the burst
	always_comb begin
		stop = cke && ((cmd == sdram_ecc_pkg::CMD_BST) ||
			((cmd == sdram_ecc_pkg::CMD_PRE) &&
			(addr[sdram_ecc_pkg::PRE_ALL_BIT] || (bank == bst_bank_reg))));
		beat_on   = 1'b0;
		beat_wr   = 1'b0;
		beat_bank = bst_bank_reg;
		beat_col  = col_at(bst_start_reg, bst_idx_reg, bst_mask_reg, ilv_reg);
		bst_on_next    = bst_on_reg;
		bst_wr_next    = bst_wr_reg;
		bst_page_next  = bst_page_reg;
		bst_bank_next  = bst_bank_reg;
		bst_start_next = bst_start_reg;
		bst_idx_next   = bst_idx_reg;
		bst_mask_next  = bst_mask_reg;
		if (cmd_rw) begin
			// a new access cuts off any running burst
			beat_on   = 1'b1;
			beat_wr   = (cmd == sdram_ecc_pkg::CMD_WR);
			beat_bank = bank;
			beat_col  = addr[COL_W-1:0];
			bst_mask_next = (beat_wr && wsingle_reg) ? '0 : mask_of(bl_reg);
			bst_page_next = (bl_reg == sdram_ecc_pkg::BL_PAGE) &&
				!(beat_wr && wsingle_reg);
			bst_on_next    = bst_page_next || (bst_mask_next != '0);
			bst_wr_next    = beat_wr;
			bst_bank_next  = bank;
			bst_start_next = addr[COL_W-1:0];
			bst_idx_next   = COL_W'(1);
		end else if (bst_on_reg && stop) begin
			bst_on_next = 1'b0;
		end else if (bst_on_reg && cke) begin
			beat_on = 1'b1;
			beat_wr = bst_wr_reg;
			bst_idx_next = bst_idx_reg + 1'b1;
			// full page keeps wrapping until terminated
			if (!bst_page_reg && (bst_idx_reg == bst_mask_reg)) begin
				bst_on_next = 1'b0;
			end
		end
		beat_half = beat_col[0];
		beat_word = {beat_bank, row_reg[beat_bank], beat_col[COL_W-1:1]};
	end

	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			bst_on_reg    <= 1'b0;
			bst_wr_reg    <= 1'b0;
			bst_page_reg  <= 1'b0;
			bst_bank_reg  <= '0;
			bst_start_reg <= '0;
			bst_idx_reg   <= '0;
			bst_mask_reg  <= '0;
		end else begin
			bst_on_reg    <= bst_on_next;
			bst_wr_reg    <= bst_wr_next;
			bst_page_reg  <= bst_page_next;
			bst_bank_reg  <= bst_bank_next;
			bst_start_reg <= bst_start_next;
			bst_idx_reg   <= bst_idx_next;
			bst_mask_reg  <= bst_mask_next;
		end
	end

	// every beat fetches its whole coded word in its own beat cycle
	sdram_word_store #(
		.AW (WA_W),
		.DW (sdram_ecc_pkg::CODE_W)
	) u_store (
		.clk     (mclk),
		.wr_en   (flush),
		.wr_addr (wb_addr_reg),
		.wr_data ({ecc_encode(merged), merged}),
		.rd_addr (beat_word),
		.rd_data (rd_word)
	);

	// correction is combinational so a cl2 read still meets its edge
	always_comb begin
		corr  = ecc_correct(rd_word);
		slice = p1_half_reg ? corr[63:32] : corr[31:0];
		p1_rd_next   = beat_on && !beat_wr;
		p1_half_next = beat_half;
		hold_v_next  = p1_rd_reg;
		hold_next    = slice;
		if (cl3_reg) begin
			dq_out_next = hold_reg;
			dq_oe_next  = hold_v_reg;
		end else begin
			dq_out_next = slice;
			dq_oe_next  = p1_rd_reg;
		end
	end

	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			p1_rd_reg   <= 1'b0;
			p1_half_reg <= 1'b0;
			hold_v_reg  <= 1'b0;
			hold_reg    <= '0;
			dq_out_reg  <= '0;
			dq_oe_reg   <= 1'b0;
		end else begin
			p1_rd_reg   <= p1_rd_next;
			p1_half_reg <= p1_half_next;
			hold_v_reg  <= hold_v_next;
			hold_reg    <= hold_next;
			dq_out_reg  <= dq_out_next;
			dq_oe_reg   <= dq_oe_next;
		end
	end

	// write beats gather per word; the old word fills bytes never written,
	// so short bursts still store a consistent code at a read-merge cost
	always_comb begin
		wr_beat  = beat_on && beat_wr;
		new_word = wr_beat && (!wb_v_reg || (beat_word != wb_addr_reg));
		flush    = wb_v_reg && (!wr_beat || new_word);
		old_use  = wb_fresh_reg ? corr : old_reg;
		for (int b = 0; b < 8; b++) begin
			merged[8*b+:8] = wb_be_reg[b] ? wb_data_reg[8*b+:8] :
				old_use[8*b+:8];
		end
		old_next      = old_use;
		wb_v_next     = wb_v_reg;
		wb_fresh_next = 1'b0;
		wb_addr_next  = wb_addr_reg;
		wb_data_next  = wb_data_reg;
		wb_be_next    = wb_be_reg;
		if (new_word) begin
			wb_v_next     = 1'b1;
			wb_fresh_next = 1'b1;
			wb_addr_next  = beat_word;
			wb_be_next    = '0;
		end else if (flush) begin
			wb_v_next = 1'b0;
		end
		if (wr_beat) begin
			for (int b = 0; b < 4; b++) begin
				if (!dqm[b]) begin
					wb_data_next[32*beat_half+8*b+:8] = dq_in[8*b+:8];
					wb_be_next[4*beat_half+b] = 1'b1;
				end
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			wb_v_reg     <= 1'b0;
			wb_fresh_reg <= 1'b0;
			wb_addr_reg  <= '0;
			wb_data_reg  <= '0;
			wb_be_reg    <= '0;
			old_reg      <= '0;
		end else begin
			wb_v_reg     <= wb_v_next;
			wb_fresh_reg <= wb_fresh_next;
			wb_addr_reg  <= wb_addr_next;
			wb_data_reg  <= wb_data_next;
			wb_be_reg    <= wb_be_next;
			old_reg      <= old_next;
		end
	end

	// pin drivers come straight from flops
	assign dq_out = dq_out_reg;
	assign dq_oe  = dq_oe_reg;

endmodule // sdram_inline_ecc_datapath
`default_nettype wire

// file: sdram_ecc_checker.sv
// port assertions for the ecc sdram datapath
`timescale 1ns/1ps
`default_nettype none
module sdram_ecc_checker (
	input wire logic        mclk,
	input wire logic        reset_n,
	input wire logic        cke,
	input wire logic        cs_n,
	input wire logic        ras_n,
	input wire logic        cas_n,
	input wire logic        we_n,
	input wire logic [11:0] addr,
	input wire logic [31:0] dq_out,
	input wire logic        dq_oe
);
	logic [3:0] cmd;
	logic       rd_t;
	logic       wr_t;
	logic       idle_t;
	logic       mode_ok;
	logic       cl3_reg;
	logic [2:0] bl_reg;

	// command decode; idle means nothing that starts, cuts or pauses a burst
	assign cmd = {cs_n, ras_n, cas_n, we_n};
	assign rd_t = cke && cmd == sdram_ecc_pkg::CMD_RD;
	assign wr_t = cke && cmd == sdram_ecc_pkg::CMD_WR;
	assign idle_t = cke && (cmd >= 4'h7 || cmd == 4'h1 || cmd == 4'h3);
	assign mode_ok = addr[6:5] == 2'h1 &&
		(!addr[2] || (addr[2:0] == 3'h7 && !addr[3]));

	// mirror of the mode word, so burst checks know what to expect
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			cl3_reg <= 1'b1;
			bl_reg  <= sdram_ecc_pkg::BL_1;
		end else if (cke && cmd == sdram_ecc_pkg::CMD_MRS && mode_ok) begin
			cl3_reg <= addr[4];
			bl_reg  <= addr[2:0];
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!reset_n);

	sequence s_quiet3;
		idle_t [*3];
	endsequence
	sequence s_quiet4;
		idle_t [*4];
	endsequence

	chk_reset_quiet: assert property (
		@(posedge mclk) disable iff (1'b0)
		!reset_n |=> !dq_oe && dq_out == 32'h0000_0000)
		else $error("data pins driven after reset");
	chk_cl2_latency: assert property (
		rd_t && !cl3_reg |-> ##2 dq_oe)
		else $error("first beat missing at latency two");
	chk_cl3_latency: assert property (
		rd_t && cl3_reg |-> ##3 dq_oe)
		else $error("first beat missing at latency three");
	chk_oe_cause: assert property (
		$rose(dq_oe) |-> $past(rd_t, 2) || $past(rd_t, 3))
		else $error("data driven without a read");
	chk_bl1_single: assert property (
		rd_t && cl3_reg && bl_reg == sdram_ecc_pkg::BL_1 ##1 s_quiet3
		|-> dq_oe ##1 !dq_oe)
		else $error("single burst wrong length");
	chk_bl2_pair: assert property (
		rd_t && !cl3_reg && bl_reg == sdram_ecc_pkg::BL_2 ##1 s_quiet3
		|-> $past(dq_oe) && dq_oe ##1 !dq_oe)
		else $error("word not sent as two halves");
	chk_bl4_run: assert property (
		rd_t && !cl3_reg && bl_reg == sdram_ecc_pkg::BL_4 ##1 s_quiet4
		|-> $past(dq_oe, 2) && $past(dq_oe) && dq_oe [*2] ##1 !dq_oe)
		else $error("burst of four wrong length");
	chk_write_quiet: assert property (
		wr_t && !dq_oe && !$past(rd_t) && !$past(rd_t, 2) &&
		!$past(rd_t, 3) ##1 s_quiet3 |-> !dq_oe [*2])
		else $error("data pins driven during a write");
endmodule // sdram_ecc_checker

bind sdram_inline_ecc_datapath sdram_ecc_checker i_chk (
	.mclk(mclk), .reset_n(reset_n), .cke(cke), .cs_n(cs_n),
	.ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .addr(addr),
	.dq_out(dq_out), .dq_oe(dq_oe));
`default_nettype wire

// file: sdram_ctrl_model.sv
// controller-side model that launches commands and write data
`timescale 1ns/1ps
`default_nettype none
module sdram_ctrl_model (
	input  wire logic        mclk,
	output logic             cke,
	output logic             cs_n,
	output logic             ras_n,
	output logic             cas_n,
	output logic             we_n,
	output logic [11:0]      addr,
	output logic             bank_select_low,
	output logic             bank_select_high,
	output logic [3:0]       dqm,
	output logic [31:0]      dq_in
);
	// start as a no-op; byte masks open, clock enable stays on
	initial begin
		cke = 1'b1;
		{cs_n, ras_n, cas_n, we_n} = sdram_ecc_pkg::CMD_NOP;
		addr = 12'h000;
		{bank_select_high, bank_select_low} = 2'h0;
		dqm = 4'h0;
		dq_in = 32'h0000_0000;
	end

	// one command just after a rising edge, held for one cycle
	task automatic issue(input logic [3:0] c, input logic [1:0] b,
		input logic [11:0] a, input logic [31:0] d);
		@(posedge mclk);
		{cs_n, ras_n, cas_n, we_n} <= c;
		{bank_select_high, bank_select_low} <= b;
		addr <= a;
		dq_in <= d;
	endtask

	// byte masks for the next write beats, set in a no-op cycle
	task automatic mask(input logic [3:0] m);
		@(posedge mclk);
		{cs_n, ras_n, cas_n, we_n} <= sdram_ecc_pkg::CMD_NOP;
		dqm <= m;
	endtask

	// released data lines toggle, so a stale value can never match
	task automatic idle(input int n);
		repeat (n) begin
			@(posedge mclk);
			{cs_n, ras_n, cas_n, we_n} <= sdram_ecc_pkg::CMD_NOP;
			dq_in <= ~dq_in;
		end
	endtask
endmodule // sdram_ctrl_model
`default_nettype wire

// file: test_sdram_inline_ecc_datapath.sv
// self-checking bench for the ecc sdram datapath
`timescale 1ns/1ps
`default_nettype none
module test_sdram_inline_ecc_datapath;
	logic        mclk = 1'b0;
	logic        reset_n = 1'b0;
	logic        cke, cs_n, ras_n, cas_n, we_n, bsl, bsh, dq_oe;
	logic [11:0] addr;
	logic [3:0]  dqm;
	logic [31:0] dq_in, dq_out;
	int          miscompares = 0;
	int          cmp_count = 0;

	sdram_ctrl_model i_ctrl (.mclk(mclk), .cke(cke), .cs_n(cs_n),
		.ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .addr(addr),
		.bank_select_low(bsl), .bank_select_high(bsh), .dqm(dqm),
		.dq_in(dq_in));
	// few rows keep the array small
	sdram_inline_ecc_datapath #(.ROW_W(4), .COL_W(8)) i_dut (.mclk(mclk),
		.reset_n(reset_n), .cke(cke), .cs_n(cs_n), .ras_n(ras_n),
		.cas_n(cas_n), .we_n(we_n), .addr(addr), .bank_select_low(bsl),
		.bank_select_high(bsh), .dqm(dqm), .dq_in(dq_in),
		.dq_out(dq_out), .dq_oe(dq_oe));

	always #4 mclk = ~mclk;

	// data pattern unique per bank and column
	function automatic logic [31:0] pat(input logic [1:0] b, input int c);
		return {8'hC3, 6'h00, b, 8'(c), 8'h5A};
	endfunction

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic final_report;
		$display("comparisons %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic mode(input logic [2:0] bl, input logic [2:0] cl,
		input logic ilv);
		i_ctrl.issue(sdram_ecc_pkg::CMD_MRS, 2'h0, {5'h00, cl, ilv, bl}, 0);
	endtask

	// whole-word bursts from an aligned column, so no word is half written
	task automatic wr(input logic [1:0] b, input int c, input int n);
		i_ctrl.issue(sdram_ecc_pkg::CMD_WR, b, 12'(c), pat(b, c));
		for (int i = 1; i < n; i++)
			i_ctrl.issue(sdram_ecc_pkg::CMD_NOP, b, 12'h000, pat(b, c + i));
	endtask

	// read, then judge the first n beats at their exact cycles; page bursts are stopped
	task automatic rd(input logic [1:0] b, input int c, input int n,
		input int cl, input bit ilv, input bit page);
		int col;
		i_ctrl.issue(sdram_ecc_pkg::CMD_RD, b, 12'(c), 32'h0);
		i_ctrl.idle(cl);
		for (int i = 0; i < n; i++) begin
			if (i > 0)
				i_ctrl.idle(1);
			#1;
			col = ilv ? (c ^ i) : ((c & ~(n - 1)) | ((c + i) & (n - 1)));
			check(dq_oe, 1'b1);
			check(dq_out, pat(b, col));
		end
		if (page)
			i_ctrl.issue(sdram_ecc_pkg::CMD_BST, b, 12'h000, 32'h0);
		else
			i_ctrl.idle(1);
		#1;
		for (int i = 0; page && dq_oe !== 1'b0; i++) begin
			if (i == 8) begin
				miscompares++;
				final_report();
			end
			i_ctrl.idle(1);
			#1;
		end
		check(dq_oe, 1'b0);
	endtask

	// both latencies, read right behind write, odd start column
	task automatic t_latency;
		for (int cl = 2; cl <= 3; cl++) begin
			mode(sdram_ecc_pkg::BL_2, 3'(cl), 1'b0);
			i_ctrl.issue(sdram_ecc_pkg::CMD_ACT, 2'h0, 12'h000, 32'h0);
			wr(2'h0, 0, 2);
			rd(2'h0, 0, 2, cl, 1'b0, 1'b0);
			rd(2'h0, 1, 2, cl, 1'b0, 1'b0);
		end
		$display("latency test done");
	endtask

	// each bank keeps its own data across a refresh; reads wrap in the block
	task automatic t_banks;
		mode(sdram_ecc_pkg::BL_8, sdram_ecc_pkg::CL_3, 1'b0);
		for (int b = 0; b < 4; b++) begin
			i_ctrl.issue(sdram_ecc_pkg::CMD_ACT, 2'(b), 12'h001, 32'h0);
			wr(2'(b), 0, 8);
		end
		i_ctrl.issue(sdram_ecc_pkg::CMD_REF, 2'h0, 12'h000, 32'h0);
		for (int b = 0; b < 4; b++)
			rd(2'(b), 3, 8, 3, 1'b0, 1'b0);
		$display("bank test done");
	endtask

	// every fixed burst length, sequential and interleaved
	task automatic t_bursts;
		for (int k = 0; k < 4; k++)
			for (int v = 0; v < 2; v++) begin
				mode(3'(k), sdram_ecc_pkg::CL_3, 1'(v));
				rd(2'h2, 5, 1 << k, 3, 1'(v), 1'b0);
			end
		$display("burst test done");
	endtask

	// illegal mode words leave the last good mode in place
	task automatic t_refused;
		mode(sdram_ecc_pkg::BL_4, sdram_ecc_pkg::CL_2, 1'b0);
		mode(sdram_ecc_pkg::BL_PAGE, sdram_ecc_pkg::CL_2, 1'b1);
		mode(sdram_ecc_pkg::BL_1, 3'h1, 1'b0);
		rd(2'h1, 2, 4, 2, 1'b0, 1'b0);
		$display("refused mode test done");
	endtask

	// full page runs on until a burst stop
	task automatic t_page;
		mode(sdram_ecc_pkg::BL_PAGE, sdram_ecc_pkg::CL_3, 1'b0);
		rd(2'h3, 0, 8, 3, 1'b0, 1'b1);
		// precharge of all banks, even another bank's, also ends the run
		i_ctrl.issue(sdram_ecc_pkg::CMD_RD, 2'h3, 12'h000, 32'h0);
		i_ctrl.idle(4);
		i_ctrl.issue(sdram_ecc_pkg::CMD_PRE, 2'h1, 12'h400, 32'h0);
		i_ctrl.idle(2);
		#1;
		check(dq_oe, 1'b1);
		i_ctrl.idle(1);
		#1;
		check(dq_oe, 1'b0);
		$display("page test done");
	endtask

	// masked single-beat write merges with the stored word; a trailing
	// beat would clobber column 0, so write single mode must hold it off
	task automatic t_masked;
		logic [31:0] hi;
		hi = (pat(2'h0, 1) & 32'h00FF_00FF) | 32'hFF00_FF00;
		// burst two, latency two, write single
		i_ctrl.issue(sdram_ecc_pkg::CMD_MRS, 2'h0, 12'h221, 32'h0);
		i_ctrl.mask(4'h5);
		i_ctrl.issue(sdram_ecc_pkg::CMD_WR, 2'h0, 12'h001, 32'hFFFF_FFFF);
		i_ctrl.idle(1);
		i_ctrl.issue(sdram_ecc_pkg::CMD_RD, 2'h0, 12'h000, 32'h0);
		i_ctrl.idle(2);
		#1;
		check(dq_out, pat(2'h0, 0));
		i_ctrl.idle(1);
		#1;
		check(dq_out, hi);
		// scrub: the original data is written back and read again
		i_ctrl.mask(4'h0);
		mode(sdram_ecc_pkg::BL_2, sdram_ecc_pkg::CL_2, 1'b0);
		wr(2'h0, 0, 2);
		rd(2'h0, 0, 2, 2, 1'b0, 1'b0);
		$display("masked write test done");
	endtask

	initial begin
		repeat (3) @(posedge mclk);
		reset_n <= 1'b1;
		t_latency();
		t_banks();
		t_bursts();
		t_refused();
		t_page();
		t_masked();
		final_report();
	end
endmodule // test_sdram_inline_ecc_datapath
`default_nettype wire
